// >>> rtl/ext_irq_defines.svh
// register offsets, field positions and reset values of the external interrupt block
// assumes inclusion by bare name from any design file
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH
`define ADDR_SENSE_SELECT 20'hEE014
`define ADDR_ENABLE 20'hEE015
`define ADDR_STATUS 20'hEE016
`define ADDR_PRIO_A 20'hEE018
`define ADDR_PRIO_B 20'hEE019
`define ADDR_IRQ_STATUS 20'hEE01C
`define ADDR_IRQ_ENABLE 20'hEE01D
`define ADDR_IRQ_CLEAR 20'hEE01E
`define NUM_SRC 6
`define RESET_BYTE 8'h00
`define PRIO_B_USED_MASK 8'hEE
`define PRIO_A_SRC0 7
`define PRIO_A_SRC1 6
`define PRIO_A_SRC23 5
`define PRIO_A_SRC45 4
`endif

// >>> rtl/ext_irq_pkg.sv
// types of the external interrupt block
// assumes nothing beyond the constant header
package ext_irq_pkg;
    typedef struct packed
    {
        logic [5:0] req;
        logic [5:0] level;
    } cpu_req_t;
    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [19:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// >>> rtl/ext_irq_source.sv
// one external request source: sense, pending flag, clear handshake
// assumes pin synchronous to CLK and a one-cycle exception-accept pulse
`timescale 1ns/1ns
module ext_irq_source
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pin and configuration
    input wire logic pin,
    input wire logic edge_mode,
    // software side
    input wire logic flag_read,
    input wire logic flag_wr0,
    // core side
    input wire logic accept,
    output logic flag
);
    logic pin_q;
    logic armed_q;
    logic flag_q;
    logic set_ev;
    logic sw_clr;
    logic hw_clr;
    assign set_ev = edge_mode ? (pin_q & ~pin) : ~pin;
    assign sw_clr = flag_wr0 & armed_q;
    assign hw_clr = accept & (edge_mode | pin);
    assign flag = flag_q;
    // previous pin level, reset high so a low pin at release counts as an edge
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pin_q <= 1'b1;
        else
            pin_q <= pin;
    end
    // read-as-one arms the clear; a zero write or a clear flag disarms it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            armed_q <= 1'b0;
        else if (flag_read)
            armed_q <= flag_q;
        else if (flag_wr0 | !flag_q)
            armed_q <= 1'b0;
    end
    // set wins over any clear in the same cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            flag_q <= 1'b0;
        else if (set_ev)
            flag_q <= 1'b1;
        else if (sw_clr | hw_clr)
            flag_q <= 1'b0;
    end
endmodule

// >>> rtl/ext_irq_ctrl.sv
// external interrupt controller with APB register slave
// assumes pins synchronous to CLK; ACCEPT pulses one cycle per handled source
`timescale 1ns/1ns
`include "ext_irq_defines.svh"
module ext_irq_ctrl
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // apb slave
    input wire ext_irq_pkg::apb_req_t APB_REQ,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // pins and core
    input wire logic [5:0] EXT_REQUEST_PIN,
    input wire logic [5:0] ACCEPT,
    output ext_irq_pkg::cpu_req_t CPU_REQ,
    output logic [7:0] PRIO_A,
    output logic [7:0] PRIO_B,
    output logic IRQ
);
    import ext_irq_pkg::*;
    logic [7:0] sense_q;
    logic [7:0] enable_q;
    logic [7:0] prio_a_q;
    logic [7:0] prio_b_q;
    logic [7:0] irq_en_q;
    logic [7:0] irq_st_q;
    logic [5:0] flags;
    logic [5:0] flags_q;
    logic [31:0] rdata_q;
    logic slverr_q;
    logic ready_q;
    cpu_req_t cpu_q;
    logic irq_q;
    logic acc_phase;
    logic wr;
    logic rd;
    logic hit_sense;
    logic hit_enable;
    logic hit_status;
    logic hit_pa;
    logic hit_pb;
    logic hit_ist;
    logic hit_ien;
    logic hit_iclr;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [5:0] src_level;
    logic [5:0] wr0;
    logic [7:0] events;
    logic [5:0] rise;
    // access decode: one wait cycle, answer on second access edge
    assign acc_phase = APB_REQ.psel & APB_REQ.penable & ~ready_q;
    assign wr = acc_phase & APB_REQ.pwrite;
    assign rd = acc_phase & ~APB_REQ.pwrite;
    assign wbyte = APB_REQ.pwdata[7:0];
    assign hit_sense = (APB_REQ.paddr == `ADDR_SENSE_SELECT);
    assign hit_enable = (APB_REQ.paddr == `ADDR_ENABLE);
    assign hit_status = (APB_REQ.paddr == `ADDR_STATUS);
    assign hit_pa = (APB_REQ.paddr == `ADDR_PRIO_A);
    assign hit_pb = (APB_REQ.paddr == `ADDR_PRIO_B);
    assign hit_ist = (APB_REQ.paddr == `ADDR_IRQ_STATUS);
    assign hit_ien = (APB_REQ.paddr == `ADDR_IRQ_ENABLE);
    assign hit_iclr = (APB_REQ.paddr == `ADDR_IRQ_CLEAR);
    assign mapped = hit_sense | hit_enable | hit_status | hit_pa | hit_pb | hit_ist | hit_ien | hit_iclr;
    // only zero bits of a status write count as clear requests
    assign wr0 = {6{wr & hit_status}} & ~wbyte[5:0];
    // read mux; unused bits read as zero
    assign rbyte = hit_sense ? sense_q :
                   hit_enable ? enable_q :
                   hit_status ? {2'b00, flags} :
                   hit_pa ? prio_a_q :
                   hit_pb ? prio_b_q :
                   hit_ist ? irq_st_q :
                   hit_ien ? irq_en_q : 8'h00;
    // per-source priority from group bits
    assign src_level = {prio_a_q[`PRIO_A_SRC45], prio_a_q[`PRIO_A_SRC45], prio_a_q[`PRIO_A_SRC23],
                        prio_a_q[`PRIO_A_SRC23], prio_a_q[`PRIO_A_SRC1], prio_a_q[`PRIO_A_SRC0]};
    // events: flag rising per source, plus unmapped access
    assign rise = flags & ~flags_q;
    assign events = {1'b0, acc_phase & ~mapped, rise};
    // one instance per external source
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SRC; gi = gi + 1)
        begin : g_src
            ext_irq_source u_src
            (
                .clk(CLK),
                .reset(RESET),
                .pin(EXT_REQUEST_PIN[gi]),
                .edge_mode(sense_q[gi]),
                .flag_read(rd & hit_status),
                .flag_wr0(wr0[gi]),
                .accept(ACCEPT[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate
    // configuration registers
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            sense_q <= `RESET_BYTE;
            enable_q <= `RESET_BYTE;
            prio_a_q <= `RESET_BYTE;
            prio_b_q <= `RESET_BYTE;
            irq_en_q <= `RESET_BYTE;
        end
        else if (wr)
        begin
            if (hit_sense)
                sense_q <= {2'b00, wbyte[5:0]};
            if (hit_enable)
                enable_q <= {2'b00, wbyte[5:0]};
            if (hit_pa)
                prio_a_q <= wbyte;
            if (hit_pb)
                prio_b_q <= wbyte & `PRIO_B_USED_MASK;
            if (hit_ien)
                irq_en_q <= wbyte;
        end
    end
    // sticky event status; a new event beats the clear
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            irq_st_q <= `RESET_BYTE;
            flags_q <= 6'h00;
        end
        else
        begin
            irq_st_q <= events | (irq_st_q & ~({8{wr & hit_iclr}} & wbyte));
            flags_q <= flags;
        end
    end
    // bus answer registers
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else
        begin
            ready_q <= acc_phase;
            rdata_q <= rd ? {24'h00_0000, rbyte} : 32'h0000_0000;
            slverr_q <= acc_phase & ~mapped;
        end
    end
    // core request, priority tag and interrupt line
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            cpu_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            cpu_q.req <= flags & enable_q[5:0];
            cpu_q.level <= src_level;
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end
    assign PREADY = ready_q;
    assign PRDATA = rdata_q;
    assign PSLVERR = slverr_q;
    assign CPU_REQ = cpu_q;
    assign PRIO_A = prio_a_q;
    assign PRIO_B = prio_b_q;
    assign IRQ = irq_q;
    // checks
    property p_level_sets;
        @(posedge CLK) disable iff (RESET) (!sense_q[0] && !EXT_REQUEST_PIN[0]) |=> flags[0];
    endproperty
    a_level_sets: assert property (p_level_sets) else $error("level low did not set flag");
    property p_edge_only;
        @(posedge CLK) disable iff (RESET)
        (sense_q[1] && !flags[1] && $stable(EXT_REQUEST_PIN[1]) && !ACCEPT[1] && $stable(sense_q[1])) |=> !flags[1];
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("edge flag set without edge");
    property p_req_gate;
        @(posedge CLK) disable iff (RESET) cpu_q.req[2] |-> $past(flags[2] & enable_q[2]);
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("request without flag and enable");
    property p_req_full;
        @(posedge CLK) disable iff (RESET) (flags[3] && enable_q[3]) |=> cpu_q.req[3];
    endproperty
    a_req_full: assert property (p_req_full) else $error("request missing");
    property p_no_sw_set;
        @(posedge CLK) disable iff (RESET)
        (!flags[4] && sense_q[4] && EXT_REQUEST_PIN[4] && $past(EXT_REQUEST_PIN[4])) |=> !flags[4];
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without source event");
    property p_edge_ack;
        @(posedge CLK) disable iff (RESET)
        (sense_q[2] && ACCEPT[2] && !(EXT_REQUEST_PIN[2] == 1'b0 && $past(EXT_REQUEST_PIN[2]))) |=> !flags[2];
    endproperty
    a_edge_ack: assert property (p_edge_ack) else $error("edge flag not cleared on accept");
    property p_level_ack;
        @(posedge CLK) disable iff (RESET) (!sense_q[3] && ACCEPT[3] && EXT_REQUEST_PIN[3]) |=> !flags[3];
    endproperty
    a_level_ack: assert property (p_level_ack) else $error("level flag not cleared");
    property p_prio_map;
        @(posedge CLK) disable iff (RESET) ##1 (cpu_q.level[5] == $past(prio_a_q[4]) && cpu_q.level[0] == $past(prio_a_q[7]));
    endproperty
    a_prio_map: assert property (p_prio_map) else $error("priority mapping wrong");
    property p_prio_b;
        @(posedge CLK) disable iff (RESET) (prio_b_q[4] == 1'b0 && prio_b_q[0] == 1'b0);
    endproperty
    a_prio_b: assert property (p_prio_b) else $error("unused priority bit set");
    property p_ready;
        @(posedge CLK) disable iff (RESET) (APB_REQ.psel && !APB_REQ.penable) |=> ##1 PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("apb answer late");
    // bus answer: one-cycle ready, refused access flagged, upper data bits zero
    property p_ready_pulse;
        @(posedge CLK) disable iff (RESET) PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held more than one cycle");
    property p_slverr;
        @(posedge CLK) disable iff (RESET) (acc_phase && !mapped) |=> (PSLVERR && PREADY);
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
    property p_rdata_zero;
        @(posedge CLK) disable iff (RESET) PREADY |-> (PRDATA[31:8] == 24'h00_0000);
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("upper read data not zero");
    // unused sense and enable bits never hold a one
    property p_unused_bits;
        @(posedge CLK) disable iff (RESET) (sense_q[7:6] == 2'b00) && (enable_q[7:6] == 2'b00);
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("unused sense or enable bit set");
    // interrupt line follows enabled sticky status one cycle later
    property p_irq_level;
        @(posedge CLK) disable iff (RESET) ##1 (IRQ == $past(|(irq_st_q & irq_en_q)));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt line wrong");
    // per-source checks over all six sources, so every scenario reaches them
    generate
        for (gi = 0; gi < `NUM_SRC; gi = gi + 1)
        begin : g_chk
            property p_gate_all;
                @(posedge CLK) disable iff (RESET) cpu_q.req[gi] == $past(flags[gi] & enable_q[gi]);
            endproperty
            a_gate_all: assert property (p_gate_all) else $error("request does not follow flag and enable");
            property p_off_quiet;
                @(posedge CLK) disable iff (RESET) !enable_q[gi] |=> !cpu_q.req[gi];
            endproperty
            a_off_quiet: assert property (p_off_quiet) else $error("disabled source requested");
            property p_no_set_high;
                @(posedge CLK) disable iff (RESET) (!flags[gi] && EXT_REQUEST_PIN[gi]) |=> !flags[gi];
            endproperty
            a_no_set_high: assert property (p_no_set_high) else $error("flag set with pin high");
            property p_clr_cause;
                @(posedge CLK) disable iff (RESET) (flags[gi] && !ACCEPT[gi] && !wr0[gi]) |=> flags[gi];
            endproperty
            a_clr_cause: assert property (p_clr_cause) else $error("flag cleared without cause");
            property p_new_kept;
                @(posedge CLK) disable iff (RESET) ($rose(flags[gi]) && !ACCEPT[gi]) |=> flags[gi];
            endproperty
            a_new_kept: assert property (p_new_kept) else $error("unread flag cleared");
            property p_level_set;
                @(posedge CLK) disable iff (RESET) (!sense_q[gi] && !EXT_REQUEST_PIN[gi]) |=> flags[gi];
            endproperty
            a_level_set: assert property (p_level_set) else $error("low level did not set flag");
            property p_edge_set;
                @(posedge CLK) disable iff (RESET)
                (sense_q[gi] && !EXT_REQUEST_PIN[gi] && $past(EXT_REQUEST_PIN[gi])) |=> flags[gi];
            endproperty
            a_edge_set: assert property (p_edge_set) else $error("falling edge did not set flag");
            property p_level_drop;
                @(posedge CLK) disable iff (RESET) (!sense_q[gi] && ACCEPT[gi] && EXT_REQUEST_PIN[gi]) |=> !flags[gi];
            endproperty
            a_level_drop: assert property (p_level_drop) else $error("level flag kept after accept");
            property p_edge_drop;
                @(posedge CLK) disable iff (RESET)
                (sense_q[gi] && ACCEPT[gi] && !(!EXT_REQUEST_PIN[gi] && $past(EXT_REQUEST_PIN[gi]))) |=> !flags[gi];
            endproperty
            a_edge_drop: assert property (p_edge_drop) else $error("edge flag kept after accept");
        end
    endgenerate
    c_edge: cover property (@(posedge CLK) disable iff (RESET) sense_q[0] && rise[0]);
    c_swclr: cover property (@(posedge CLK) disable iff (RESET) wr0[0] && flags[0] ##1 !flags[0]);
    c_irq: cover property (@(posedge CLK) disable iff (RESET) IRQ);
    c_hold: cover property (@(posedge CLK) disable iff (RESET) !sense_q[3] && ACCEPT[3] && !EXT_REQUEST_PIN[3]);
    c_refused: cover property (@(posedge CLK) disable iff (RESET) PSLVERR && PREADY);
endmodule

// >>> tb/ext_irq_core_model.sv
// core-side model: answers granted requests with one-cycle accept pulses
// assumes the controller's clock; the bench picks which sources are served
`timescale 1ns/1ns
module ext_irq_core_model
#(
    parameter int DLY = 3
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // controller side
    input wire ext_irq_pkg::cpu_req_t cpu_req,
    input wire logic [5:0] grant,
    output logic [5:0] accept
);
    import ext_irq_pkg::*;
    logic [5:0] live;
    logic [5:0] pick;
    logic [3:0] wait_q;
    // lowest pending source wins, as a one-hot pick
    assign live = cpu_req.req & grant;
    assign pick = live & ~(live - 6'h01);
    // slow handling: the wait outlasts the request's fall after a pulse
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wait_q <= 4'h0;
            accept <= 6'h00;
        end
        else
        begin
            accept <= (pick != 6'h00 && wait_q == 4'(DLY)) ? pick : 6'h00;
            wait_q <= (pick == 6'h00 || wait_q == 4'(DLY)) ? 4'h0 : wait_q + 4'h1;
        end
    end
endmodule

// >>> tb/tb_top.sv
// self-checking bench of the external interrupt controller
// assumes the controller, its package and the core model are compiled first
`timescale 1ns/1ns
`include "ext_irq_defines.svh"
module tb_top;
    import ext_irq_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    apb_req_t req = '0;
    logic [5:0] pins = 6'h3F;
    logic [5:0] grant = 6'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] accept;
    cpu_req_t cpu_req;
    logic [7:0] prio_a;
    logic [7:0] prio_b;
    logic irq;
    logic [31:0] rd;
    logic er;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    ext_irq_ctrl i_ext_irq_ctrl (.CLK(clk), .RESET(reset), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_REQUEST_PIN(pins), .ACCEPT(accept), .CPU_REQ(cpu_req), .PRIO_A(prio_a),
        .PRIO_B(prio_b), .IRQ(irq));
    ext_irq_core_model i_ext_irq_core_model (.clk(clk), .reset(reset), .cpu_req(cpu_req), .grant(grant),
        .accept(accept));
    // 50 ns clock
    initial
    begin
        forever #25 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            failures++;
    endtask
    // one transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [19:0] addr, input logic [7:0] data);
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, addr, {24'h000000, data}};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        // no cycle count assumed; only the hang guard ends this wait
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [19:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 8'h00);
        chk(rd, {24'h000000, exp});
    endtask
    // wait for the core model to drain all requests; the hang guard bounds it
    task automatic drain();
        while (cpu_req.req !== 6'h00)
            @(posedge clk);
    endtask
    task automatic t_reset();
        rdchk(`ADDR_SENSE_SELECT, 8'h00);
        rdchk(`ADDR_ENABLE, 8'h00);
        rdchk(`ADDR_STATUS, 8'h00);
        rdchk(`ADDR_PRIO_A, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_level();
        apb(1'b1, `ADDR_ENABLE, 8'h01);
        pins <= 6'h3C;
        repeat (3) @(posedge clk);
        chk(32'(cpu_req.req), 32'h00000001);
        pins <= 6'h3F;
        rdchk(`ADDR_STATUS, 8'h03);
        apb(1'b1, `ADDR_STATUS, 8'hFF);
        rdchk(`ADDR_STATUS, 8'h03);
        apb(1'b1, `ADDR_STATUS, 8'hFE);
        rdchk(`ADDR_STATUS, 8'h02);
        // source 2 sets after the read, so its zero write must not clear it
        pins <= 6'h3B;
        @(posedge clk);
        pins <= 6'h3F;
        apb(1'b1, `ADDR_ENABLE, 8'h00);
        apb(1'b1, `ADDR_STATUS, 8'h00);
        rdchk(`ADDR_STATUS, 8'h04);
        apb(1'b1, `ADDR_STATUS, 8'h00);
        rdchk(`ADDR_STATUS, 8'h00);
        $display("test level and clear done");
    endtask
    task automatic t_edge();
        apb(1'b1, `ADDR_SENSE_SELECT, 8'h3F);
        apb(1'b1, `ADDR_ENABLE, 8'h3F);
        pins <= 6'h3B;
        repeat (3) @(posedge clk);
        chk(32'(cpu_req.req), 32'h00000004);
        grant <= 6'h3F;
        drain();
        rdchk(`ADDR_STATUS, 8'h00);
        pins <= 6'h3F;
        $display("test edge done");
    endtask
    task automatic t_hold();
        apb(1'b1, `ADDR_SENSE_SELECT, 8'h00);
        pins <= 6'h37;
        repeat (20) @(posedge clk);
        rdchk(`ADDR_STATUS, 8'h08);
        pins <= 6'h3F;
        drain();
        rdchk(`ADDR_STATUS, 8'h00);
        grant <= 6'h00;
        $display("test level handling done");
    endtask
    task automatic t_prio();
        apb(1'b1, `ADDR_PRIO_A, 8'hB0);
        apb(1'b1, `ADDR_PRIO_B, 8'hFF);
        rdchk(`ADDR_PRIO_B, 8'hEE);
        chk(32'(prio_b), 32'h000000EE);
        rdchk(`ADDR_PRIO_A, 8'hB0);
        chk(32'(cpu_req.level), 32'h0000003D);
        apb(1'b1, `ADDR_PRIO_A, 8'h4F);
        repeat (2) @(posedge clk);
        chk(32'(cpu_req.level), 32'h00000002);
        chk(32'(prio_a), 32'h0000004F);
        $display("test priority done");
    endtask
    task automatic t_irq();
        apb(1'b1, `ADDR_IRQ_CLEAR, 8'h7F);
        apb(1'b1, `ADDR_IRQ_ENABLE, 8'h40);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h00000000);
        rdchk(20'hEE017, 8'h00);
        chk(32'(er), 32'h00000001);
        rdchk(`ADDR_IRQ_STATUS, 8'h40);
        chk(32'(irq), 32'h00000001);
        apb(1'b1, `ADDR_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h00000000);
        apb(1'b1, `ADDR_IRQ_ENABLE, 8'h40);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h00000001);
        apb(1'b1, `ADDR_IRQ_CLEAR, 8'h40);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h00000000);
        $display("test interrupt done");
    endtask
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence after a two-cycle reset
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_level();
        t_edge();
        t_hold();
        t_prio();
        t_irq();
        test_done();
    end
endmodule
